/* rtl/timer_event_flags_consts.vh */
`ifndef TIMER_EVENT_FLAGS_CONSTS_VH
`define TIMER_EVENT_FLAGS_CONSTS_VH

// Layout of the timer control/status word
`define TCS_WORD_WIDTH 24
`define TCS_OVF_IRQ_EN_BIT 1
`define TCS_CMP_IRQ_EN_BIT 2
`define TCS_OVF_FLAG_BIT 20
`define TCS_CMP_FLAG_BIT 21

// Reset values
`define TCS_IRQ_EN_RESET 1'h0
`define TCS_FLAG_RESET 1'h0
`define TCS_WORD_ZERO 24'h00_0000

`endif

/* rtl/sticky_event_flag.v */
`timescale 1ns/10ps
`include "timer_event_flags_consts.vh"

module sticky_event_flag (
  input wire clk,
  input wire rst,
  input wire set_pulse,
  input wire wr_clear,
  input wire ack_clear,
  output wire flag
);

  reg flag_q;
  reg flag_d;

  // Set beats clear so an event in the clearing cycle is kept
  always @* begin
    flag_d = flag_q;
    if (wr_clear || ack_clear) begin
      flag_d = 1'b0;
    end
    if (set_pulse) begin
      flag_d = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= `TCS_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule

/* rtl/timer_event_flags_irq.v */
`timescale 1ns/10ps
`include "timer_event_flags_consts.vh"

// Behaviour
// - Compare match sets the compare event flag at word bit 21.
// - Writing one to bit 21 or servicing compare interrupt clears it.
// - Counter wraparound sets the overflow event flag at word bit 20.
// - Writing one to bit 20 or servicing overflow interrupt clears it.
// - Overflow enable zero blocks overflow requests; one allows them.
// - Compare enable at bit 2; zero blocks, one allows compare requests.
// - Overflow interrupt enable sits at bit 1 of the same word.
module timer_event_flags_irq #(
  parameter WORD_WIDTH = `TCS_WORD_WIDTH
) (
  input wire REF_CLK,
  input wire RST,
  input wire COMPARE_MATCH,
  input wire COUNTER_WRAP,
  input wire CSR_WR,
  input wire [WORD_WIDTH-1:0] CSR_WDATA,
  input wire COMPARE_IRQ_ACK,
  input wire OVERFLOW_IRQ_ACK,
  output wire [WORD_WIDTH-1:0] CSR_RDATA,
  output wire COMPARE_IRQ,
  output wire OVERFLOW_IRQ
);

  // Field map of the word, gathered so it reads in one place
  localparam CMP_FLAG_POS = `TCS_CMP_FLAG_BIT;
  localparam OVF_FLAG_POS = `TCS_OVF_FLAG_BIT;
  localparam CMP_EN_POS = `TCS_CMP_IRQ_EN_BIT;
  localparam OVF_EN_POS = `TCS_OVF_IRQ_EN_BIT;

  // Enable state
  reg compare_irq_enable_q;
  reg compare_irq_enable_d;
  reg overflow_irq_enable_q;
  reg overflow_irq_enable_d;

  // Read view
  reg [WORD_WIDTH-1:0] rdata_d;

  // Event and service inputs
  wire cmp_set;
  wire ovf_set;
  wire cmp_ack;
  wire ovf_ack;

  // Flag state
  wire compare_event_flag;
  wire overflow_event_flag;

  // Clear requests
  wire cmp_wr_clear;
  wire ovf_wr_clear;

  // Request levels
  wire cmp_req;
  wire ovf_req;

  // True when a write carries a one at the given position
  function write_one_at;
    input wr;
    input [WORD_WIDTH-1:0] data;
    input integer pos;
    begin
      write_one_at = wr && data[pos];
    end
  endfunction

  // A write always reloads an enable; otherwise it holds
  function enable_next;
    input wr;
    input [WORD_WIDTH-1:0] data;
    input integer pos;
    input cur;
    begin
      if (wr) begin
        enable_next = data[pos];
      end else begin
        enable_next = cur;
      end
    end
  endfunction

  // A request stands only while flag and enable are both set
  function request_level;
    input flag;
    input enable;
    begin
      request_level = flag && enable;
    end
  endfunction

  // Drops one status bit into the read word
  function [WORD_WIDTH-1:0] place_bit;
    input [WORD_WIDTH-1:0] word;
    input integer pos;
    input value;
    begin
      place_bit = word;
      place_bit[pos] = value;
    end
  endfunction

  assign cmp_set = COMPARE_MATCH;
  assign ovf_set = COUNTER_WRAP;
  assign cmp_ack = COMPARE_IRQ_ACK;
  assign ovf_ack = OVERFLOW_IRQ_ACK;

  // Writing zero to a flag position leaves the flag alone
  assign cmp_wr_clear = write_one_at(
    CSR_WR,
    CSR_WDATA,
    CMP_FLAG_POS
  );

  assign ovf_wr_clear = write_one_at(
    CSR_WR,
    CSR_WDATA,
    OVF_FLAG_POS
  );

  // Set beats clear inside the cell, so no event is lost
  sticky_event_flag u_cmp_flag (
    .clk(REF_CLK),
    .rst(RST),
    .set_pulse(cmp_set),
    .wr_clear(cmp_wr_clear),
    .ack_clear(cmp_ack),
    .flag(compare_event_flag)
  );

  sticky_event_flag u_ovf_flag (
    .clk(REF_CLK),
    .rst(RST),
    .set_pulse(ovf_set),
    .wr_clear(ovf_wr_clear),
    .ack_clear(ovf_ack),
    .flag(overflow_event_flag)
  );

  // Both enables follow every write: no partial write exists
  always @* begin
    compare_irq_enable_d = enable_next(
      CSR_WR,
      CSR_WDATA,
      CMP_EN_POS,
      compare_irq_enable_q
    );
  end

  always @* begin
    overflow_irq_enable_d = enable_next(
      CSR_WR,
      CSR_WDATA,
      OVF_EN_POS,
      overflow_irq_enable_q
    );
  end

  // Enables start cleared so no request leaks out of reset
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      compare_irq_enable_q <= `TCS_IRQ_EN_RESET;
    end else begin
      compare_irq_enable_q <= compare_irq_enable_d;
    end
  end

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      overflow_irq_enable_q <= `TCS_IRQ_EN_RESET;
    end else begin
      overflow_irq_enable_q <= overflow_irq_enable_d;
    end
  end

  // Other bits of the word belong elsewhere and read zero here
  always @* begin
    rdata_d = `TCS_WORD_ZERO;
    rdata_d = place_bit(
      rdata_d,
      CMP_FLAG_POS,
      compare_event_flag
    );
    rdata_d = place_bit(
      rdata_d,
      OVF_FLAG_POS,
      overflow_event_flag
    );
    rdata_d = place_bit(
      rdata_d,
      CMP_EN_POS,
      compare_irq_enable_q
    );
    rdata_d = place_bit(
      rdata_d,
      OVF_EN_POS,
      overflow_irq_enable_q
    );
  end

  assign CSR_RDATA = rdata_d;

  // Level requests, dropped as soon as the flag clears
  assign cmp_req = request_level(
    compare_event_flag,
    compare_irq_enable_q
  );

  assign ovf_req = request_level(
    overflow_event_flag,
    overflow_irq_enable_q
  );

  assign COMPARE_IRQ = cmp_req;
  assign OVERFLOW_IRQ = ovf_req;

endmodule

/* tb/timer_event_flags_irq_chk.sv */
`timescale 1ns/10ps
module ef_chk(input wire REF_CLK,RST,COMPARE_MATCH,COUNTER_WRAP,CSR_WR,
  COMPARE_IRQ_ACK,OVERFLOW_IRQ_ACK,COMPARE_IRQ,OVERFLOW_IRQ,
  input wire [23:0] CSR_WDATA,CSR_RDATA);
wire cf=CSR_RDATA[21];
wire of=CSR_RDATA[20];
default clocking @(posedge REF_CLK);endclocking
default disable iff (RST);
a_cmp_set:assert property(COMPARE_MATCH|=>cf)else $error("cf");
a_cmp_clr:assert property(COMPARE_IRQ_ACK&&!COMPARE_MATCH|=>!cf)else $error("cf");
a_ovf_set:assert property(COUNTER_WRAP|=>of)else $error("of");
a_ovf_clr:assert property(OVERFLOW_IRQ_ACK&&!COUNTER_WRAP|=>!of)else $error("of");
a_ovf_gate:assert property(OVERFLOW_IRQ==(of&&CSR_RDATA[1]))else $error("oi");
a_cmp_gate:assert property(COMPARE_IRQ==(cf&&CSR_RDATA[2]))else $error("ci");
a_en_write:assert property(CSR_WR|=>CSR_RDATA[2:1]==$past(CSR_WDATA[2:1]))else $error("en");
a_en_hold:assert property(!CSR_WR|=>$stable(CSR_RDATA[2:1]))else $error("en");
endmodule
bind timer_event_flags_irq ef_chk u_chk(.*);

/* tb/irq_svc.sv */
`timescale 1ns/10ps
module irq_svc #(parameter D=0)(input wire c,r,i,output reg a);
integer n;
// D sets how slow service is
always @(posedge c or posedge r)
  if(r)begin n<=0;a<=0;end
  else begin a<=i&&!a&&n==D;n<=i&&!a&&n<D?n+1:0;end
endmodule

/* tb/tb_timer_event_flags_irq.sv */
`timescale 1ns/10ps
module tb_timer_event_flags_irq;
reg c=0,r=1;
reg [2:0] v=0;
reg [23:0] d=0;
wire [23:0] q;
wire ci,oi,ca,oa;
integer error_cnt=0,n_compared=0,k;
initial forever #5 c=~c;
timer_event_flags_irq DUT(.REF_CLK(c),.RST(r),.COMPARE_MATCH(v[2]),.COUNTER_WRAP(v[1]),
  .CSR_WR(v[0]),.CSR_WDATA(d),.COMPARE_IRQ_ACK(ca),.OVERFLOW_IRQ_ACK(oa),.CSR_RDATA(q),
  .COMPARE_IRQ(ci),.OVERFLOW_IRQ(oi));
irq_svc P0(.c(c),.r(r),.i(ci),.a(ca));
irq_svc #(3) P1(.c(c),.r(r),.i(oi),.a(oa));
task chk(input [25:0] e);begin n_compared++;
  if({ci,oi,q}!==e)begin error_cnt++;$display("mismatch out %h %h",e,{ci,oi,q});end
end endtask
task go(input [2:0] x,input [23:0] y);begin @(posedge c);v<=x;d<=y;@(posedge c);v<=0;#1;end
endtask
task t_sw;begin
  go(5,24'h00_0006);chk(26'h220_0006);
  go(3,24'h20_0006);chk(26'h110_0006);
  go(1,24'h00_0004);chk(26'h010_0004);
  go(1,24'h10_0004);chk(26'h000_0004);
end endtask
task t_gate;begin
  go(5,24'h20_0002);chk(26'h020_0002);
  go(1,24'h20_0002);chk(26'h000_0002);
end endtask
task t_ack;begin go(7,24'h00_0006);for(k=0;k<20&&q[21:20]!==2'b00;k++)#10;
  if(k==20)error_cnt++;
  chk(26'h000_0006);
end endtask
task summarize;begin $display("cmp %0d err %0d",n_compared,error_cnt);
  if(error_cnt==0&&n_compared>0)$display("[ PASS ]");else $display("[ FAIL ]");$finish;
end endtask
initial begin repeat(4)@(posedge c);r<=0;t_sw;t_gate;t_ack;summarize;end
endmodule
